// [hdl/stop_ctrl.sv]
// stop-condition trigger logic of one two-wire bus master channel, with a wishbone register slave
// assumes open-drain lines resolved outside; registers on the system clock, lines sampled twice
//
// Summary of operation
// - on stop trigger in a wait: drive data low, release clock, wait hold time, release data
// - no stop condition is produced while the stop trigger is zero
// - wait timing zero and stop in eight-clock wait: stop straight from the wait, no ninth clock; stop set after wait release: stop in ninth clock high
// - once set, further writes of one to the stop trigger are ignored
// - stop trigger clears on a detected stop condition and on arbitration loss
// - stop trigger clears on reset, bus release command and channel disabled
// - when transmitting, wait release ends the ninth-clock wait, clears transmit, frees data
// - the stop trigger reads zero right after it was written
// - master status sets on start, clears on stop, arbitration loss, release, disable
`timescale 1ns/10ps
`include "stop_ctrl_regs.svh"
module stop_ctrl
  import stop_ctrl_pkg::*;
#(
  parameter int HOLD_CYCLES = `STOP_HOLD_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sclOe,
  output logic sdaOe
);
  line_sync_if lines ();
  line_sampler sampler (.clock(clock), .rst_n(rst_n), .sclPin(sclPin), .sdaPin(sdaPin), .lines(lines));

  bus_state_t state_q, state_d;
  logic chanEn_q, chanEn_d, startTrig_q, startTrig_d, stopTrig_q, stopTrig_d;
  logic acknowledge_enable_q, acknowledge_enable_d, waitTiming_q, waitTiming_d, resvDis_q, resvDis_d;
  logic master_q, master_d, transmit_q, transmit_d, waiting_q, waiting_d;
  logic stopSeen_q, stopSeen_d, arbLost_q, arbLost_d, busy_q, busy_d;
  logic sclOe_q, sclOe_d, sdaOe_q, sdaOe_d, ack_q, ack_d, readBack_q, readBack_d;
  logic [31:0] dat_q, dat_d;
  logic [15:0] div_q, div_d, cnt_q, cnt_d;
  logic [3:0] bits_q, bits_d;
  logic [7:0] shift_q, shift_d;
  logic wr, rd, ctrlWr, relCmd, waitRel;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr == off;
  endfunction : hit

  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;
  assign ctrlWr = wr & hit(wb_adr_i, `CTRL_OFFSET) & wb_sel_i[0] & wb_sel_i[1];
  assign relCmd = ctrlWr & wb_dat_i[`CTRL_BUS_RELEASE_COMMAND];
  assign waitRel = ctrlWr & wb_dat_i[`CTRL_WAIT_RELEASE];

  // register slave and control bits
  always_comb begin
    chanEn_d = chanEn_q;
    acknowledge_enable_d = acknowledge_enable_q;
    waitTiming_d = waitTiming_q;
    resvDis_d = resvDis_q;
    div_d = div_q;
    startTrig_d = startTrig_q;
    stopTrig_d = stopTrig_q;
    readBack_d = readBack_q & ~rd;
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    dat_d = 32'h0000_0000;
    if (ctrlWr) begin
      chanEn_d = wb_dat_i[`CTRL_CHANNEL_ENABLE];
      acknowledge_enable_d = wb_dat_i[`CTRL_ACKNOWLEDGE_ENABLE];
      waitTiming_d = wb_dat_i[`CTRL_WAIT_TIMING_SELECT];
      resvDis_d = wb_dat_i[`CTRL_RESERVATION_DISABLE];
      readBack_d = 1'b1;
      if (wb_dat_i[`CTRL_START_TRIGGER] && !startTrig_q) begin
        startTrig_d = 1'b1;
      end
      if (wb_dat_i[`CTRL_STOP_TRIGGER] && !stopTrig_q) begin
        stopTrig_d = 1'b1;
      end
    end
    if (wr && hit(wb_adr_i, `CLKDIV_OFFSET) && wb_sel_i[0] && wb_sel_i[1]) begin
      div_d = wb_dat_i[15:0];
    end
    if (state_q == StartHigh && cnt_q == 16'h0000) begin
      startTrig_d = 1'b0;
    end
    if (lines.stopSeen || arbLost_d && !arbLost_q) begin
      stopTrig_d = 1'b0;
      startTrig_d = 1'b0;
    end
    if (relCmd || !chanEn_d) begin
      stopTrig_d = 1'b0;
      startTrig_d = 1'b0;
    end
    if (rd) begin
      if (hit(wb_adr_i, `CTRL_OFFSET)) begin
        dat_d[`CTRL_CHANNEL_ENABLE] = chanEn_q;
        dat_d[`CTRL_START_TRIGGER] = startTrig_q & ~readBack_q;
        dat_d[`CTRL_STOP_TRIGGER] = stopTrig_q & ~readBack_q;
        dat_d[`CTRL_ACKNOWLEDGE_ENABLE] = acknowledge_enable_q;
        dat_d[`CTRL_WAIT_TIMING_SELECT] = waitTiming_q;
        dat_d[`CTRL_RESERVATION_DISABLE] = resvDis_q;
      end else if (hit(wb_adr_i, `STAT_OFFSET)) begin
        dat_d[`STAT_MASTER_STATUS] = master_q;
        dat_d[`STAT_TRANSMIT_STATUS] = transmit_q;
        dat_d[`STAT_WAITING] = waiting_q;
        dat_d[`STAT_STOP_SEEN] = stopSeen_q;
        dat_d[`STAT_ARB_LOST] = arbLost_q;
        dat_d[`STAT_STOP_TRIGGER] = stopTrig_q;
        dat_d[`STAT_BUS_BUSY] = busy_q;
        dat_d[`STAT_BIT_COUNT] = bits_q;
      end else if (hit(wb_adr_i, `CLKDIV_OFFSET)) begin
        dat_d[15:0] = div_q;
      end
    end
  end

  // bus sequencer: bit clocking, waits, start and stop generation
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q == 16'h0000 ? 16'h0000 : cnt_q - 16'h0001;
    bits_d = bits_q;
    shift_d = shift_q;
    sclOe_d = sclOe_q;
    sdaOe_d = sdaOe_q;
    master_d = master_q;
    transmit_d = transmit_q;
    waiting_d = waiting_q;
    arbLost_d = arbLost_q;
    stopSeen_d = stopSeen_q | lines.stopSeen;
    busy_d = lines.startSeen ? 1'b1 : (lines.stopSeen ? 1'b0 : busy_q);
    if (rd && hit(wb_adr_i, `STAT_OFFSET)) begin
      stopSeen_d = lines.stopSeen;
      arbLost_d = 1'b0;
    end
    if (ctrlWr && wb_dat_i[`CTRL_TRANSMIT]) begin
      transmit_d = 1'b1;
      shift_d = wb_dat_i[31:24];
    end
    unique case (state_q)
      BusIdle: begin
        sclOe_d = 1'b0;
        if (startTrig_q && !busy_q && !stopTrig_q) begin
          sdaOe_d = 1'b1;
          cnt_d = div_q;
          state_d = StartHigh;
        end else if (stopTrig_q && master_q) begin
          state_d = StopLow;
          cnt_d = div_q;
        end
      end
      StartHigh: if (cnt_q == 16'h0000) begin
        sclOe_d = 1'b1;
        master_d = 1'b1;
        bits_d = 4'h0;
        cnt_d = div_q;
        state_d = BitLow;
      end
      BitLow: if (cnt_q != 16'h0000) begin
        // data changes only while the clock is held low
        sdaOe_d = bits_q == 4'h8 ? ~transmit_q & acknowledge_enable_q : transmit_q & ~shift_q[7];
      end else begin
        sclOe_d = 1'b0;
        cnt_d = div_q;
        state_d = BitHigh;
        if (bits_q == 4'h8 && stopTrig_q && !waitTiming_q) begin
          sdaOe_d = 1'b1;
          state_d = StopHigh;
        end
      end
      BitHigh: if (lines.sclIn && cnt_q == 16'h0000) begin
        if (transmit_q && !sdaOe_q && !lines.sdaIn && bits_q < 4'h8 && shift_q[7]) begin
          arbLost_d = 1'b1;
          master_d = 1'b0;
          sclOe_d = 1'b0;
          state_d = BusIdle;
        end else begin
          sclOe_d = 1'b1;
          bits_d = bits_q + 4'h1;
          shift_d = {shift_q[6:0], 1'b1};
          cnt_d = div_q;
          state_d = BitLow;
          if (bits_q == 4'h7 && !waitTiming_q || bits_q == 4'h8) begin
            waiting_d = 1'b1;
            state_d = WaitHold;
          end
        end
      end
      WaitHold: begin
        sclOe_d = 1'b1;
        if (stopTrig_q) begin
          sdaOe_d = 1'b1;
          cnt_d = div_q;
          waiting_d = 1'b0;
          state_d = StopLow;
        end else if (waitRel) begin
          waiting_d = 1'b0;
          if (bits_q == 4'h9) begin
            bits_d = 4'h0;
          end
          if (transmit_q && bits_q == 4'h9) begin
            transmit_d = 1'b0;
            sdaOe_d = 1'b0;
          end
          cnt_d = div_q;
          state_d = BitLow;
        end
      end
      StopLow: if (cnt_q == 16'h0000 && stopTrig_q) begin
        sdaOe_d = 1'b1;
        sclOe_d = 1'b0;
        cnt_d = 16'(HOLD_CYCLES);
        state_d = StopHigh;
      end
      StopHigh: if (lines.sclIn && cnt_q == 16'h0000) begin
        sdaOe_d = 1'b0;
        state_d = StopDone;
      end
      StopDone: if (lines.stopSeen || !stopTrig_q) begin
        state_d = BusIdle;
      end
    endcase
    if (lines.stopSeen) begin
      master_d = 1'b0;
    end
    if (relCmd || !chanEn_q) begin
      master_d = 1'b0;
      transmit_d = 1'b0;
      waiting_d = 1'b0;
      sclOe_d = 1'b0;
      sdaOe_d = 1'b0;
      state_d = BusIdle;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chanEn_q <= 1'b0;
      acknowledge_enable_q <= 1'b0;
      waitTiming_q <= 1'b0;
      resvDis_q <= 1'b0;
      startTrig_q <= 1'b0;
      stopTrig_q <= 1'b0;
      div_q <= `CLKDIV_RESET;
      readBack_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= `CTRL_RESET;
    end else begin
      chanEn_q <= chanEn_d;
      acknowledge_enable_q <= acknowledge_enable_d;
      waitTiming_q <= waitTiming_d;
      resvDis_q <= resvDis_d;
      startTrig_q <= startTrig_d;
      stopTrig_q <= stopTrig_d;
      div_q <= div_d;
      readBack_q <= readBack_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BusIdle;
      cnt_q <= 16'h0000;
      bits_q <= 4'h0;
      shift_q <= 8'h00;
      sclOe_q <= 1'b0;
      sdaOe_q <= 1'b0;
      master_q <= 1'b0;
      transmit_q <= 1'b0;
      waiting_q <= 1'b0;
      arbLost_q <= 1'b0;
      stopSeen_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bits_q <= bits_d;
      shift_q <= shift_d;
      sclOe_q <= sclOe_d;
      sdaOe_q <= sdaOe_d;
      master_q <= master_d;
      transmit_q <= transmit_d;
      waiting_q <= waiting_d;
      arbLost_q <= arbLost_d;
      stopSeen_q <= stopSeen_d;
      busy_q <= busy_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign sclOe = sclOe_q;
  assign sdaOe = sdaOe_q;
endmodule : stop_ctrl

// [hdl/stop_ctrl_regs.svh]
// register offsets, field positions, reset values and timing counts of the stop-condition controller
// assumes a 32-bit classic wishbone slave with word-aligned registers
`ifndef STOP_CTRL_REGS_SVH
`define STOP_CTRL_REGS_SVH
`define CTRL_OFFSET 8'h00
`define STAT_OFFSET 8'h04
`define CLKDIV_OFFSET 8'h08
`define CTRL_CHANNEL_ENABLE 0
`define CTRL_START_TRIGGER 1
`define CTRL_STOP_TRIGGER 2
`define CTRL_ACKNOWLEDGE_ENABLE 3
`define CTRL_WAIT_TIMING_SELECT 4
`define CTRL_BUS_RELEASE_COMMAND 5
`define CTRL_RESERVATION_DISABLE 6
`define CTRL_WAIT_RELEASE 7
`define CTRL_TRANSMIT 8
`define STAT_MASTER_STATUS 0
`define STAT_TRANSMIT_STATUS 1
`define STAT_WAITING 2
`define STAT_STOP_SEEN 3
`define STAT_ARB_LOST 4
`define STAT_STOP_TRIGGER 5
`define STAT_BUS_BUSY 6
`define STAT_BIT_COUNT 10:7
`define CTRL_RESET 32'h0000_0000
`define CLKDIV_RESET 16'h0019
`define STOP_HOLD_NS 4000
`define CLOCK_NS 40
`define STOP_HOLD_CYCLES ((`STOP_HOLD_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`endif

// [hdl/stop_ctrl_pkg.sv]
// types shared by the stop-condition controller modules
// assumes the header of constants for offsets and counts
package stop_ctrl_pkg;
  typedef enum logic [2:0] {
    BusIdle, BitLow, BitHigh, WaitHold, StartHigh, StopLow, StopHigh, StopDone
  } bus_state_t;
endpackage : stop_ctrl_pkg

// [hdl/line_sync_if.sv]
// synchronised view of the two serial lines, shared between sampler and controller
// assumes both ends on the same clock
`timescale 1ns/10ps
interface line_sync_if;
  logic sclIn;
  logic sdaIn;
  logic startSeen;
  logic stopSeen;
  modport sampler (output sclIn, output sdaIn, output startSeen, output stopSeen);
  modport user (input sclIn, input sdaIn, input startSeen, input stopSeen);
endinterface : line_sync_if

// [hdl/line_sampler.sv]
// two-flop synchroniser for the clock and data lines plus start and stop detection
// assumes pins asynchronous to clock; idle lines are high
`timescale 1ns/10ps
module line_sampler (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclPin,
  input wire logic sdaPin,
  line_sync_if.sampler lines
);
  logic [1:0] sclMeta_q, sclMeta_d;
  logic [1:0] sdaMeta_q, sdaMeta_d;
  logic sdaLast_q, sdaLast_d;

  always_comb begin
    sclMeta_d = {sclMeta_q[0], sclPin};
    sdaMeta_d = {sdaMeta_q[0], sdaPin};
    sdaLast_d = sdaMeta_q[1];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclMeta_q <= 2'h3;
      sdaMeta_q <= 2'h3;
      sdaLast_q <= 1'b1;
    end else begin
      sclMeta_q <= sclMeta_d;
      sdaMeta_q <= sdaMeta_d;
      sdaLast_q <= sdaLast_d;
    end
  end

  assign lines.sclIn = sclMeta_q[1];
  assign lines.sdaIn = sdaMeta_q[1];
  assign lines.startSeen = sclMeta_q[1] & sdaLast_q & ~sdaMeta_q[1];
  assign lines.stopSeen = sclMeta_q[1] & ~sdaLast_q & sdaMeta_q[1];
endmodule : line_sampler

// [sim/stop_ctrl_asserts.sv]
// port checker of the stop-condition controller
// assumes binding to stop_ctrl, single clock domain
`timescale 1ns/10ps
`include "stop_ctrl_regs.svh"
module stop_ctrl_asserts #(
  parameter int HOLD_CYCLES = `STOP_HOLD_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sclPin,
  input wire logic sdaPin,
  input wire logic sclOe,
  input wire logic sdaOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence ctrlWrite;
    wb_ack_o && wb_we_i && wb_adr_i == `CTRL_OFFSET && wb_sel_i[1:0] == 2'b11;
  endsequence
  sequence linesFree;
    !sclOe && !sdaOe;
  endsequence
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h0b |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_STOP_HOLD: assert property ($fell(sdaOe) && !sclOe && $past(!sclOe) |-> $past(sdaOe && !sclOe, HOLD_CYCLES))
    else $error("data released too soon after clock");
  AST_DISABLE_FREE: assert property (ctrlWrite ##0 !wb_dat_i[0] |-> ##[0:3] linesFree)
    else $error("lines held after disable");
  AST_RELEASE_FREE: assert property (ctrlWrite ##0 wb_dat_i[5] |-> ##[0:3] linesFree)
    else $error("lines held after release command");
endmodule : stop_ctrl_asserts

bind stop_ctrl stop_ctrl_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) watch (.clock(clock), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sclPin(sclPin), .sdaPin(sdaPin),
  .sclOe(sclOe), .sdaOe(sdaOe));

// [sim/bus_partner.sv]
// serial bus far side: pull-ups, a slave acking only the first byte after each start or stop, a competing master
// assumes open-drain enables, high = pull line low
`timescale 1ns/10ps
module bus_partner (
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic grab,
  output logic sclPin,
  output logic sdaPin
);
  int bitCount = 0;
  logic ackLow = 1'b0;
  // released lines float high through the pull-ups
  assign sclPin = ~sclOe;
  assign sdaPin = ~(sdaOe | ackLow | grab);
  // start or stop restarts the byte
  always @(sdaPin) begin
    if (sclPin === 1'b1) begin
      bitCount = -1;
      ackLow = 1'b0;
    end
  end
  // acknowledge held through the ninth clock
  always @(negedge sclPin) begin
    bitCount = bitCount + 1;
    ackLow = (bitCount == 8);
  end
endmodule : bus_partner

// [sim/i2c_stop_condition_control_bench.sv]
// self-checking bench of the stop-condition controller
// assumes stop_ctrl, bus_partner and the checker bound to it
`timescale 1ns/10ps
`include "stop_ctrl_regs.svh"
module i2c_stop_condition_control_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic we = 1'b0;
  logic grab = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] datI = 32'h0000_0000;
  logic [31:0] datO;
  logic [31:0] s;
  logic ack, sclPin, sdaPin, sclOe, sdaOe;
  int badCount = 0;
  int comparisons = 0;
  always #20 clock = ~clock;
  stop_ctrl #(.HOLD_CYCLES(4)) dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .sclPin(sclPin), .sdaPin(sdaPin), .sclOe(sclOe), .sdaOe(sdaOe));
  bus_partner partner (.sclOe(sclOe), .sdaOe(sdaOe), .grab(grab), .sclPin(sclPin), .sdaPin(sdaPin));

  task give_verdict;
    if (badCount == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task hang;
    badCount++;
    give_verdict;
  endtask : hang

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // one classic cycle; read data lands in s
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    req <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) hang;
    s = datO;
    req <= 1'b0;
  endtask : bus

  task poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, `STAT_OFFSET, 32'h0000_0000);
      n++;
    end while (s[b] !== v && n < 200);
    if (n >= 200) hang;
  endtask : poll

  // start, send one byte, wait in the wait after the ninth clock
  task begin_byte(input logic [7:0] b);
    bus(1'b1, `CTRL_OFFSET, 32'h0000_0013);
    poll(`STAT_MASTER_STATUS, 1'b1);
    check(s[`STAT_MASTER_STATUS], 1'b1);
    bus(1'b1, `CTRL_OFFSET, {b, 24'h00_0111});
    poll(`STAT_WAITING, 1'b1);
  endtask : begin_byte

  task test_reset;
    bus(1'b0, `CTRL_OFFSET, 32'h0000_0000);
    check(s, `CTRL_RESET);
    bus(1'b0, `CLKDIV_OFFSET, 32'h0000_0000);
    check(s, {16'h0000, `CLKDIV_RESET});
    bus(1'b1, 8'h0c, 32'hffff_ffff);
    bus(1'b0, 8'h0c, 32'h0000_0000);
    check(s, 32'h0000_0000);
    bus(1'b1, `CLKDIV_OFFSET, 32'h0000_0004);
  endtask : test_reset

  task test_stop;
    begin_byte(8'ha0);
    repeat (20) @(negedge clock);
    check(sclOe, 1'b1);
    bus(1'b0, `STAT_OFFSET, 32'h0000_0000);
    check(s[`STAT_STOP_SEEN], 1'b0);
    bus(1'b1, `CTRL_OFFSET, 32'h0000_0015);
    bus(1'b1, `CTRL_OFFSET, 32'h0000_0015);
    bus(1'b0, `CTRL_OFFSET, 32'h0000_0000);
    check(s[`CTRL_STOP_TRIGGER], 1'b0);
    poll(`STAT_STOP_SEEN, 1'b1);
    check(s[`STAT_STOP_TRIGGER], 1'b0);
    check(s[`STAT_MASTER_STATUS], 1'b0);
    check({sclOe, sdaOe}, 2'b00);
    repeat (100) @(negedge clock);
    bus(1'b0, `STAT_OFFSET, 32'h0000_0000);
    check(s[`STAT_STOP_SEEN], 1'b0);
  endtask : test_stop

  // wait release after the ninth clock, one received byte, then stop
  task test_wait_release;
    begin_byte(8'h5a);
    bus(1'b0, `STAT_OFFSET, 32'h0000_0000);
    check(s[`STAT_TRANSMIT_STATUS], 1'b1);
    bus(1'b1, `CTRL_OFFSET, 32'h0000_0091);
    bus(1'b0, `STAT_OFFSET, 32'h0000_0000);
    check(s[`STAT_TRANSMIT_STATUS], 1'b0);
    check(s[`STAT_WAITING], 1'b0);
    check(sdaOe, 1'b0);
    poll(`STAT_WAITING, 1'b1);
    bus(1'b1, `CTRL_OFFSET, 32'h0000_0015);
    poll(`STAT_STOP_SEEN, 1'b1);
    check(s[`STAT_STOP_TRIGGER], 1'b0);
    check(s[`STAT_MASTER_STATUS], 1'b0);
  endtask : test_wait_release

  task test_disable;
    begin_byte(8'ha0);
    bus(1'b1, `CTRL_OFFSET, 32'h0000_0015);
    bus(1'b1, `CTRL_OFFSET, 32'h0000_0000);
    bus(1'b0, `STAT_OFFSET, 32'h0000_0000);
    check(s[`STAT_STOP_TRIGGER], 1'b0);
    check(s[`STAT_MASTER_STATUS], 1'b0);
    check({sclOe, sdaOe}, 2'b00);
  endtask : test_disable

  task test_release;
    bus(1'b1, `CTRL_OFFSET, 32'h0000_0003);
    poll(`STAT_MASTER_STATUS, 1'b1);
    bus(1'b1, `CTRL_OFFSET, 32'h0000_0021);
    bus(1'b0, `STAT_OFFSET, 32'h0000_0000);
    check(s[`STAT_MASTER_STATUS], 1'b0);
    check({sclOe, sdaOe}, 2'b00);
    // another master opens and closes the bus so that it reads free again
    grab <= 1'b1;
    repeat (4) @(posedge clock);
    grab <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : test_release

  // a second master holds data low while an all-ones byte goes out
  task test_arbitration;
    bus(1'b1, `CTRL_OFFSET, 32'h0000_0003);
    poll(`STAT_MASTER_STATUS, 1'b1);
    grab <= 1'b1;
    bus(1'b1, `CTRL_OFFSET, 32'hff00_0111);
    poll(`STAT_ARB_LOST, 1'b1);
    check(s[`STAT_MASTER_STATUS], 1'b0);
    check(s[`STAT_STOP_TRIGGER], 1'b0);
    grab <= 1'b0;
  endtask : test_arbitration

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    test_reset;
    test_stop;
    test_wait_release;
    test_disable;
    test_release;
    test_arbitration;
    give_verdict;
  end
endmodule : i2c_stop_condition_control_bench
